// ==== hw/osc_ctrl.sv ====
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "osc_cfg.svh"
module osc_ctrl #(
  parameter int unsigned SU_OSC = `OSC_SU_OSC_COUNT
)(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [`OSC_AW-1:0]   awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [`OSC_AW-1:0]   araddr,
  input  wire logic [2:0]           arprot,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic [2:0]           cfg_clock_source_field,
  input  wire logic                 cfg_pll_enable,
  input  wire logic                 cfg_clock_output_enable,
  input  wire logic                 cfg_power_up_timer_en,
  input  wire logic                 cfg_two_speed_en,
  input  wire logic                 cfg_clock_failure_monitor_en,
  input  wire logic                 power_up_delay_done,
  input  wire logic                 sleep_enter,
  input  wire logic                 sleep_wake,
  input  wire logic                 lf_request,
  input  wire logic                 oscillator_input_pin,
  input  wire logic                 cur_clk_level,
  input  wire logic                 new_clk_level,
  input  wire logic                 hf_running,
  input  wire logic                 hf_within_2pct,
  input  wire logic                 hf_within_half_pct,
  input  wire logic                 mf_running,
  input  wire logic                 lf_running,
  input  wire logic                 t1_osc_ready,
  output logic                      high_freq_enable,
  output logic                      medium_freq_enable,
  output logic                      low_freq_enable,
  output logic                      internal_multiplier_loop_enable,
  output logic                      pll4x_enable,
  output logic [5:0]                freq_trim,
  output osc_pkg::osc_src_t         sys_clock_source,
  output logic [3:0]                active_freq_select,
  output logic                      clk_hold_low,
  output logic                      cpu_hold,
  output logic                      startup_done,
  output logic                      osc_in_pin_gpio,
  output logic                      osc_out_pin_clkout,
  output logic                      osc_out_pin_gpio
);
  localparam int unsigned CW = $clog2(SU_OSC + 1);

  logic [8:0]         async_in;
  logic [8:0]         sync_q;
  logic [2:0]         edge_d_ff;
  logic               osc_rise;
  logic               cur_fall;
  logic               new_rise;
  logic               is_xtal;
  logic               is_int_mode;
  logic               is_rc;
  logic               int_req;
  logic               keep_running;
  logic               hf_rdy;
  logic               hf_lock;
  logic               hf_stab;
  logic               mf_rdy;
  logic               lf_rdy;
  logic               t1_rdy;
  logic               tgt_rdy;
  logic [8:0]         status;

  logic               aw_held_ff;
  logic [`OSC_AW-1:0] waddr_ff;
  logic               w_held_ff;
  logic [31:0]        wdata_ff;
  logic               wstrb0_ff;
  logic               wr_fire;
  logic               wr_ctrl;
  logic               wr_trim;
  logic [31:0]        nxt_rdata;
  logic               nxt_rerr;

  logic [1:0]         scs_ff;
  logic [3:0]         ifs_ff;
  logic               spll_ff;
  logic [5:0]         trim_ff;

  osc_pkg::osc_su_t   su_state_ff;
  logic [CW-1:0]      su_cnt_ff;
  osc_pkg::osc_sw_t   sw_state_ff;
  logic [3:0]         target_ff;
  logic [3:0]         active_ifs_ff;

  function automatic logic ifs_is_hf(input logic [3:0] f);
    ifs_is_hf = (f >= `OSC_IFS_HF_MIN);
  endfunction

  function automatic logic ifs_is_lf(input logic [3:0] f);
    ifs_is_lf = (f == `OSC_IFS_LF);
  endfunction

  // pins and analog status come from outside this clock domain
  assign async_in = {t1_osc_ready, lf_running, mf_running,
                     hf_within_half_pct, hf_within_2pct, hf_running,
                     new_clk_level, cur_clk_level, oscillator_input_pin};

  osc_sync #(
    .W (9)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (async_in),
    .q       (sync_q)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_d_ff <= 3'h0;
    end else begin
      edge_d_ff <= sync_q[2:0];
    end
  end

  assign osc_rise = sync_q[0] & ~edge_d_ff[0];
  assign cur_fall = ~sync_q[1] & edge_d_ff[1];
  assign new_rise = sync_q[2] & ~edge_d_ff[2];

  // clock mode decode
  assign is_xtal     = (cfg_clock_source_field == `OSC_FOSC_LP) ||
                       (cfg_clock_source_field == `OSC_FOSC_XT) ||
                       (cfg_clock_source_field == `OSC_FOSC_HS);
  assign is_int_mode = (cfg_clock_source_field == `OSC_FOSC_INT); // [R25]
  assign is_rc       = (cfg_clock_source_field == `OSC_FOSC_RC);

  // axi4-lite write path
  assign awready = ~aw_held_ff;
  assign wready  = ~w_held_ff;
  assign wr_fire = aw_held_ff & w_held_ff & ~bvalid;
  assign wr_ctrl = wr_fire & wstrb0_ff & (waddr_ff == `OSC_ADDR_CTRL);
  assign wr_trim = wr_fire & wstrb0_ff & (waddr_ff == `OSC_ADDR_TRIM);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      waddr_ff   <= '0;
    end else if (awvalid && awready) begin
      aw_held_ff <= 1'b1;
      waddr_ff   <= awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff  <= 32'h0;
      wstrb0_ff <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_ff <= 1'b1;
      wdata_ff  <= wdata;
      wstrb0_ff <= wstrb[0];
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `OSC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (waddr_ff == `OSC_ADDR_CTRL ||
                 waddr_ff == `OSC_ADDR_STAT ||
                 waddr_ff == `OSC_ADDR_TRIM) ?
                `OSC_RESP_OKAY : `OSC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // control and trim registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scs_ff  <= `OSC_SCS_RST; // [R23]
      ifs_ff  <= `OSC_IFS_RST; // [R24]
      spll_ff <= 1'b0;
    end else if (wr_ctrl) begin
      scs_ff  <= wdata_ff[`OSC_CTRL_SCS_LSB +: 2]; // [R09]
      ifs_ff  <= wdata_ff[`OSC_CTRL_IFS_LSB +: 4]; // [R11]
      spll_ff <= wdata_ff[`OSC_CTRL_SPLL_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_ff <= `OSC_TRIM_RST; // [R17]
    end else if (wr_trim) begin
      trim_ff <= wdata_ff[5:0]; // [R17] [R19]
    end
  end

  // one trim drives the medium base, never the low source
  assign freq_trim = trim_ff; // [R18] [R20]

  // status flags track live, synchronised oscillator state
  assign hf_rdy  = sync_q[3] & high_freq_enable; // [R13]
  assign hf_lock = hf_rdy & sync_q[4]; // [R14]
  assign hf_stab = hf_rdy & sync_q[5]; // [R15]
  assign mf_rdy  = sync_q[6] & medium_freq_enable; // [R16]
  assign lf_rdy  = sync_q[7] & low_freq_enable; // [R22]
  assign t1_rdy  = sync_q[8];
  assign status  = {sw_state_ff != osc_pkg::OSC_SW_IDLE, t1_rdy,
                    pll4x_enable, startup_done, lf_rdy, mf_rdy,
                    hf_stab, hf_lock, hf_rdy};

  // axi4-lite read path
  assign arready = ~rvalid;

  always_comb begin
    nxt_rdata = 32'h0;
    nxt_rerr  = 1'b0;
    case (araddr)
      `OSC_ADDR_CTRL: begin
        nxt_rdata[`OSC_CTRL_SCS_LSB +: 2] = scs_ff;
        nxt_rdata[`OSC_CTRL_IFS_LSB +: 4] = ifs_ff;
        nxt_rdata[`OSC_CTRL_SPLL_BIT]     = spll_ff;
      end
      `OSC_ADDR_STAT: nxt_rdata[8:0] = status;
      `OSC_ADDR_TRIM: nxt_rdata[5:0] = trim_ff;
      default:        nxt_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `OSC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= nxt_rdata;
      rresp  <= nxt_rerr ? `OSC_RESP_SLVERR : `OSC_RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // crystal start-up counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      su_state_ff <= osc_pkg::OSC_SU_WAIT;
      su_cnt_ff   <= '0;
    end else if (sleep_enter) begin
      su_state_ff <= osc_pkg::OSC_SU_SLEEP;
    end else if (sleep_wake) begin
      su_cnt_ff   <= '0; // [R27]
      su_state_ff <= is_xtal ? osc_pkg::OSC_SU_COUNT
                             : osc_pkg::OSC_SU_DONE; // [R02]
    end else begin
      case (su_state_ff)
        osc_pkg::OSC_SU_WAIT: begin
          if (!is_xtal) begin
            su_state_ff <= osc_pkg::OSC_SU_DONE;
          end else if (!cfg_power_up_timer_en || power_up_delay_done) begin
            su_cnt_ff   <= '0; // [R27]
            su_state_ff <= osc_pkg::OSC_SU_COUNT; // [R02]
          end
        end
        osc_pkg::OSC_SU_COUNT: begin
          if (osc_rise) begin
            if (su_cnt_ff == CW'(SU_OSC - 1)) begin
              su_state_ff <= osc_pkg::OSC_SU_DONE; // [R01]
            end else begin
              su_cnt_ff <= su_cnt_ff + 1'b1; // [R01]
            end
          end
        end
        osc_pkg::OSC_SU_DONE:  su_state_ff <= osc_pkg::OSC_SU_DONE;
        osc_pkg::OSC_SU_SLEEP: su_state_ff <= osc_pkg::OSC_SU_SLEEP;
        default:               su_state_ff <= osc_pkg::OSC_SU_WAIT;
      endcase
    end
  end

  assign startup_done = (su_state_ff == osc_pkg::OSC_SU_DONE);
  assign keep_running = cfg_two_speed_en | cfg_clock_failure_monitor_en;
  assign cpu_hold     = is_xtal & ~keep_running &
                        (su_state_ff == osc_pkg::OSC_SU_WAIT ||
                         su_state_ff == osc_pkg::OSC_SU_COUNT); // [R03]

  // system clock source selection
  always_comb begin
    if (scs_ff[1]) begin
      sys_clock_source = osc_pkg::OSC_SRC_INT; // [R23]
    end else if (scs_ff == `OSC_SCS_T1) begin
      sys_clock_source = osc_pkg::OSC_SRC_T1; // [R06]
    end else if (is_int_mode) begin
      sys_clock_source = osc_pkg::OSC_SRC_INT; // [R09]
    end else if (is_xtal && !startup_done && keep_running) begin
      sys_clock_source = osc_pkg::OSC_SRC_INT; // [R04]
    end else begin
      sys_clock_source = osc_pkg::OSC_SRC_EXT;
    end
  end

  // internal source enables cover both requested and active choice
  assign int_req = (sys_clock_source == osc_pkg::OSC_SRC_INT);
  assign high_freq_enable = int_req &
    (ifs_is_hf(ifs_ff) | ifs_is_hf(active_ifs_ff)); // [R12]
  assign internal_multiplier_loop_enable = high_freq_enable; // [R10]
  assign medium_freq_enable = high_freq_enable | (int_req &
    (~ifs_is_hf(ifs_ff) & ~ifs_is_lf(ifs_ff) |
     ~ifs_is_hf(active_ifs_ff) & ~ifs_is_lf(active_ifs_ff))); // [R16]
  assign low_freq_enable = lf_request | (int_req &
    (ifs_is_lf(ifs_ff) | ifs_is_lf(active_ifs_ff))); // [R21]
  assign pll4x_enable = cfg_pll_enable | spll_ff; // [R05]

  // pin functions
  assign osc_in_pin_gpio    = is_int_mode; // [R08]
  assign osc_out_pin_clkout = (is_int_mode | is_rc) &
                              cfg_clock_output_enable; // [R07]
  assign osc_out_pin_gpio   = (is_int_mode | is_rc) &
                              ~cfg_clock_output_enable; // [R07]

  // glitch-free internal frequency switch
  assign tgt_rdy = ifs_is_lf(target_ff) ? lf_rdy :
                   ifs_is_hf(target_ff) ? hf_rdy : mf_rdy;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_state_ff   <= osc_pkg::OSC_SW_IDLE;
      target_ff     <= `OSC_IFS_RST;
      active_ifs_ff <= `OSC_IFS_RST;
    end else begin
      case (sw_state_ff)
        osc_pkg::OSC_SW_IDLE: begin
          if (ifs_ff != active_ifs_ff) begin
            if (!int_req) begin
              active_ifs_ff <= ifs_ff;
            end else begin
              target_ff   <= ifs_ff;
              sw_state_ff <= osc_pkg::OSC_SW_START;
            end
          end
        end
        osc_pkg::OSC_SW_START: begin
          if (ifs_ff != target_ff) begin
            target_ff <= ifs_ff;
          end else if (tgt_rdy) begin
            sw_state_ff <= osc_pkg::OSC_SW_FALL;
          end
        end
        osc_pkg::OSC_SW_FALL: begin
          if (cur_fall) begin
            sw_state_ff <= osc_pkg::OSC_SW_RISE; // [R26]
          end
        end
        osc_pkg::OSC_SW_RISE: begin
          if (new_rise) begin
            active_ifs_ff <= target_ff; // [R26]
            sw_state_ff   <= osc_pkg::OSC_SW_IDLE;
          end
        end
        default: sw_state_ff <= osc_pkg::OSC_SW_IDLE;
      endcase
    end
  end

  assign active_freq_select = active_ifs_ff; // [R11]
  assign clk_hold_low = (sw_state_ff == osc_pkg::OSC_SW_RISE); // [R26]

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_values: assert property (disable iff (1'b0) // [R24]
    !aresetn |=> scs_ff == `OSC_SCS_RST && ifs_ff == `OSC_IFS_RST &&
                 trim_ff == `OSC_TRIM_RST)
    else $error("control or trim not at reset value");

  chk_count_end: assert property ( // [R01]
    su_state_ff == osc_pkg::OSC_SU_COUNT && osc_rise && !sleep_enter &&
    !sleep_wake && su_cnt_ff == CW'(SU_OSC - 1) |=> startup_done)
    else $error("start-up count did not finish at full count");

  chk_done_cause: assert property ( // [R01]
    $rose(startup_done) && is_xtal && !$past(sleep_wake) |->
    $past(su_cnt_ff) == CW'(SU_OSC - 1))
    else $error("start-up finished early");

  chk_wake_restart: assert property ( // [R27]
    sleep_wake && !sleep_enter && is_xtal |=>
    su_cnt_ff == '0 && su_state_ff == osc_pkg::OSC_SU_COUNT)
    else $error("wake did not restart start-up count");

  chk_hold_exec: assert property ( // [R03]
    su_state_ff == osc_pkg::OSC_SU_COUNT && is_xtal && !keep_running
    |-> cpu_hold)
    else $error("execution not held during start-up count");

  chk_two_speed: assert property ( // [R04]
    su_state_ff == osc_pkg::OSC_SU_COUNT && keep_running &&
    scs_ff == `OSC_SCS_RST |-> !cpu_hold &&
    sys_clock_source == osc_pkg::OSC_SRC_INT)
    else $error("internal clock not used during two-speed start");

  chk_pll_cfg: assert property ( // [R05]
    cfg_pll_enable |-> pll4x_enable)
    else $error("config pll bit overridden by software");

  chk_hf_chain: assert property ( // [R10]
    high_freq_enable |-> medium_freq_enable &&
    internal_multiplier_loop_enable)
    else $error("high source on without its base");

  chk_lock_flag: assert property ( // [R14]
    hf_lock || hf_stab |-> hf_rdy && high_freq_enable)
    else $error("lock or stable flag without ready source");

  chk_trim_write: assert property ( // [R19]
    trim_ff != $past(trim_ff) |-> $past(wr_trim))
    else $error("trim changed without a write");

  chk_switch_hold: assert property ( // [R26]
    sw_state_ff == osc_pkg::OSC_SW_FALL && cur_fall |=> clk_hold_low)
    else $error("clock not held low after current clock fell");

  chk_hold_wait: assert property ( // [R26]
    clk_hold_low && !new_rise |=> clk_hold_low)
    else $error("clock hold released before new clock rose");

  chk_switch_take: assert property ( // [R26]
    clk_hold_low && new_rise |=>
    !clk_hold_low && active_ifs_ff == $past(target_ff))
    else $error("new clock not made active on its rising edge");

  cov_count_done:  cover property ($rose(startup_done) && is_xtal);
  cov_freq_switch: cover property ($fell(clk_hold_low));
  cov_trim_write:  cover property (wr_trim);
  cov_timer1_sel:  cover property (sys_clock_source ==
                                   osc_pkg::OSC_SRC_T1);
endmodule
`default_nettype wire

// ==== hw/osc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for asynchronous levels
module osc_sync #(
  parameter int unsigned W = 1
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ==== inc/osc_cfg.svh ====
// What this block does
// R01: crystal modes count 1024 input oscillations first
// R02: count starts after power-up delay or wake
// R03: execution held while count runs, normally
// R04: two-speed or monitor runs code from internal
// R05: pll on by config or software bit
// R06: secondary crystal selectable as system clock
// R07: output pin is gpio or clock out
// R08: internal mode frees input pin as gpio
// R09: internal block by default, config or select
// R10: high source derived from medium via loop
// R11: frequency select picks divided internal frequency
// R12: high source enable from select and mode
// R13: high source ready flag when running
// R14: locked flag within two percent
// R15: stable flag within half percent
// R16: medium source same enables, own ready
// R17: six bit signed trim, reset zero
// R18: one trim shifts medium and high together
// R19: trim shifts gradually, no completion flag
// R20: trim never reaches low frequency source
// R21: low source selected by code zero, internal
// R22: low source ready flag when running
// R23: select 00 config, 01 secondary, 1x internal
// R24: frequency select resets to 0111
// R25: config field 100 means internal block
// R26: frequency change waits fall, hold, rise
// R27: start-up count restarts from zero
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH

`define OSC_AW            8
`define OSC_ADDR_CTRL     8'h00
`define OSC_ADDR_STAT     8'h04
`define OSC_ADDR_TRIM     8'h08

`define OSC_CTRL_SCS_LSB  0
`define OSC_CTRL_IFS_LSB  3
`define OSC_CTRL_SPLL_BIT 7

`define OSC_SCS_RST       2'h0
`define OSC_SCS_T1        2'h1
`define OSC_IFS_RST       4'h7
`define OSC_IFS_LF        4'h0
`define OSC_IFS_HF_MIN    4'h8
`define OSC_TRIM_RST      6'h00

`define OSC_FOSC_LP       3'h0
`define OSC_FOSC_XT       3'h1
`define OSC_FOSC_HS       3'h2
`define OSC_FOSC_RC       3'h3
`define OSC_FOSC_INT      3'h4

`define OSC_SU_OSC_COUNT  1024

`define OSC_RESP_OKAY     2'h0
`define OSC_RESP_SLVERR   2'h2

`endif

// ==== inc/osc_pkg.sv ====
package osc_pkg;
  typedef enum logic [1:0] {
    OSC_SRC_EXT,
    OSC_SRC_T1,
    OSC_SRC_INT
  } osc_src_t;

  typedef enum logic [1:0] {
    OSC_SU_WAIT,
    OSC_SU_COUNT,
    OSC_SU_DONE,
    OSC_SU_SLEEP
  } osc_su_t;

  typedef enum logic [1:0] {
    OSC_SW_IDLE,
    OSC_SW_START,
    OSC_SW_FALL,
    OSC_SW_RISE
  } osc_sw_t;
endpackage

// ==== verification/osc_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module osc_far_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic high_freq_enable,
  input  wire logic medium_freq_enable,
  input  wire logic low_freq_enable,
  output logic      oscillator_input_pin,
  output logic      hf_running,
  output logic      hf_within_2pct,
  output logic      hf_within_half_pct,
  output logic      mf_running,
  output logic      lf_running,
  output logic      cur_clk_level,
  output logic      new_clk_level,
  output logic      t1_osc_ready
);
  logic [11:0] hf_ff;
  logic [3:0]  mf_ff;
  logic [3:0]  lf_ff;
  logic [5:0]  div_ff;
  // sources settle some cycles after enable and stop at once when off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hf_ff  <= 12'h000;
      mf_ff  <= 4'h0;
      lf_ff  <= 4'h0;
      div_ff <= 6'h00;
    end else begin
      hf_ff  <= high_freq_enable ? {hf_ff[10:0], 1'b1} : 12'h000;
      mf_ff  <= medium_freq_enable ? {mf_ff[2:0], 1'b1} : 4'h0;
      lf_ff  <= low_freq_enable ? {lf_ff[2:0], 1'b1} : 4'h0;
      div_ff <= (div_ff == 6'h3B) ? 6'h00 : div_ff + 6'h01;
    end
  end
  // locked before stable, both after running
  assign hf_running           = hf_ff[3];
  assign hf_within_2pct       = hf_ff[7];
  assign hf_within_half_pct   = hf_ff[11];
  assign mf_running           = mf_ff[3];
  assign lf_running           = lf_ff[3];
  // crystal period of six cycles, internal clocks of six and ten
  assign oscillator_input_pin = (div_ff % 6'h06) < 6'h03;
  assign cur_clk_level        = (div_ff % 6'h06) < 6'h03;
  assign new_clk_level        = (div_ff % 6'h0A) < 6'h05;
  assign t1_osc_ready         = aresetn;
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [3:0]  wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [2:0]  cfg_clock_source_field = 3'h1;
  logic        cfg_pll_enable = 1'b0, cfg_clock_output_enable = 1'b0;
  logic        cfg_power_up_timer_en = 1'b1, cfg_two_speed_en = 1'b0;
  logic        cfg_clock_failure_monitor_en = 1'b0;
  logic        power_up_delay_done = 1'b0, lf_request = 1'b0;
  logic        sleep_enter = 1'b0, sleep_wake = 1'b0;
  logic        oscillator_input_pin, cur_clk_level, new_clk_level;
  logic        hf_running, hf_within_2pct, hf_within_half_pct;
  logic        mf_running, lf_running, t1_osc_ready;
  logic        high_freq_enable, medium_freq_enable, low_freq_enable;
  logic        internal_multiplier_loop_enable, pll4x_enable;
  logic [5:0]  freq_trim;
  logic [3:0]  active_freq_select;
  logic        clk_hold_low, cpu_hold, startup_done;
  logic        osc_in_pin_gpio, osc_out_pin_clkout, osc_out_pin_gpio;
  logic        pin_q = 1'b0;
  int          err_total = 0, total_checks = 0, n, edges = 0;
  int          holds = 0, hold_mark = 0;
  osc_pkg::osc_src_t sys_clock_source;

  always #4 aclk = ~aclk;
  osc_ctrl #(.SU_OSC(8)) DUT (.*);
  osc_far_model far_end (.*);

  // crystal rising edges seen since the count was allowed to start
  always @(posedge aclk) begin
    pin_q <= oscillator_input_pin;
    if (!power_up_delay_done || sleep_wake)
      edges <= 0;
    else if (oscillator_input_pin && !pin_q)
      edges <= edges + 1;
    if (clk_hold_low === 1'b1)
      holds <= holds + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 100);
    if (k >= 100) err_total++;
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    int k;
    k = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 100);
    if (k >= 100) err_total++;
    rd   = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic count_run;
    repeat (10) @(posedge aclk);
    chk(startup_done, 1'b0);
    for (n = 0; n < 300 && startup_done !== 1'b1; n++) @(posedge aclk);
    chk(startup_done, 1'b1);
    chk(32'(edges >= 7 && edges <= 9), 32'h1);
    chk(cpu_hold, 1'b0);
  endtask

  task automatic complete_run;
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(startup_done, 1'b0);
    chk(cpu_hold, 1'b1);
    chk(osc_in_pin_gpio, 1'b0);
    chk(sys_clock_source, osc_pkg::OSC_SRC_EXT);
    rd_reg(8'h00);
    chk(rd, 32'h38);
    rd_reg(8'h08);
    chk(rd, 32'h0);
    power_up_delay_done <= 1'b1;
    chk(cpu_hold, 1'b1);
    count_run();
    cfg_two_speed_en <= 1'b1;
    sleep_enter <= 1'b1;
    @(posedge aclk);
    sleep_enter <= 1'b0;
    sleep_wake <= 1'b1;
    @(posedge aclk);
    sleep_wake <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(startup_done, 1'b0);
    chk(cpu_hold, 1'b0);
    count_run();
    chk(pll4x_enable, 1'b0);
    wr(8'h00, 32'hB8);
    chk(pll4x_enable, 1'b1);
    cfg_pll_enable <= 1'b1;
    wr(8'h00, 32'h38);
    chk(pll4x_enable, 1'b1);
    cfg_pll_enable <= 1'b0;
    wr(8'h08, 32'h20);
    rd_reg(8'h08);
    chk(rd, 32'h20);
    chk(freq_trim, 6'h20);
    chk(pll4x_enable, 1'b0);
    wr(8'h0C, 32'h1);
    chk(resp, 2'h2);
    rd_reg(8'h0C);
    chk(resp, 2'h2);
    cfg_clock_source_field <= 3'h4;
    cfg_clock_output_enable <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(osc_in_pin_gpio, 1'b1);
    chk(osc_out_pin_clkout, 1'b1);
    chk(osc_out_pin_gpio, 1'b0);
    chk(sys_clock_source, osc_pkg::OSC_SRC_INT);
    cfg_clock_output_enable <= 1'b0;
    wr(8'h00, 32'h39);
    chk(osc_out_pin_gpio, 1'b1);
    chk(sys_clock_source, osc_pkg::OSC_SRC_T1);
    wr(8'h00, 32'h3A);
    chk(sys_clock_source, osc_pkg::OSC_SRC_INT);
    chk(medium_freq_enable, 1'b1);
    repeat (12) @(posedge aclk);
    rd_reg(8'h04);
    chk(rd & 32'h8, 32'h8);
    hold_mark = holds;
    wr(8'h00, 32'h02);
    for (n = 0; n < 300 && active_freq_select !== 4'h0; n++) @(posedge aclk);
    chk(active_freq_select, 4'h0);
    chk(32'(holds > hold_mark), 32'h1);
    chk(low_freq_enable, 1'b1);
    rd_reg(8'h04);
    chk(rd & 32'h10, 32'h10);
    wr(8'h00, 32'h7A);
    for (n = 0; n < 300 && active_freq_select !== 4'hF; n++) @(posedge aclk);
    chk(active_freq_select, 4'hF);
    chk(high_freq_enable, 1'b1);
    chk(internal_multiplier_loop_enable, 1'b1);
    repeat (16) @(posedge aclk);
    rd_reg(8'h04);
    chk(rd & 32'h7, 32'h7);
    cfg_clock_source_field <= 3'h1;
    wr(8'h00, 32'h78);
    repeat (4) @(posedge aclk);
    chk(high_freq_enable, 1'b0);
    lf_request <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(low_freq_enable, 1'b1);
    cfg_clock_source_field <= 3'h3;
    cfg_clock_output_enable <= 1'b1;
    @(posedge aclk);
    chk(osc_out_pin_clkout, 1'b1);
    chk(osc_out_pin_gpio, 1'b0);
    chk(osc_in_pin_gpio, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
